// file: hw/csrg_params.svh
// constants for the processor supervisor and sram guard
//
// What this block does
// - supply fault raises power-fail, asserts reset
// - reset held 250ms after supply recovers
// - debounced button press gives 250ms reset
// - watchdog expiry without strobe forces reset
// - sram select blocked during power transients
// - sram supply from battery below switch point
// - reset pin open-drain, doubles as button
// - watchdog strobe and button ignored until power-up interval ends
`ifndef CSRG_PARAMS_SVH
`define CSRG_PARAMS_SVH

// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define CSRG_CLK_HZ          25000000
`define CSRG_CLK_PER_MS      (`CSRG_CLK_HZ / 1000)

// ---------------------------------------------------------------
// timing in milliseconds
// ---------------------------------------------------------------
`define CSRG_RESET_HOLD_MS   250
`define CSRG_WATCHDOG_MS     1500
`define CSRG_DEBOUNCE_MS     10

// ---------------------------------------------------------------
// timing in clock cycles
// ---------------------------------------------------------------
`define CSRG_RESET_HOLD_CYC  (`CSRG_CLK_PER_MS * `CSRG_RESET_HOLD_MS)
`define CSRG_WATCHDOG_CYC    (`CSRG_CLK_PER_MS * `CSRG_WATCHDOG_MS)
`define CSRG_DEBOUNCE_CYC    (`CSRG_CLK_PER_MS * `CSRG_DEBOUNCE_MS)

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define CSRG_CNT_W           32
`define CSRG_CNT_ZERO        32'h0000_0000

`endif

// file: hw/csrg_pkg.sv
// types for the processor supervisor and sram guard
package csrg_pkg;

    // -----------------------------------------------------------
    // supervisor states, one-hot
    // -----------------------------------------------------------
    typedef enum logic [3:0] {
        SUP_POWERUP = 4'h1,
        SUP_FAIL    = 4'h2,
        SUP_HOLD    = 4'h4,
        SUP_RUN     = 4'h8
    } csrg_state_type;

    // -----------------------------------------------------------
    // supervisor state record
    // -----------------------------------------------------------
    typedef struct packed {
        csrg_state_type state;
        logic [31:0]    holdCnt;
        logic [31:0]    dogCnt;
        logic           rstDriveOe;
        logic           powerFail;
        logic           ramSelectOutN;
        logic           batterySelect;
    } csrg_sup_type;

    // -----------------------------------------------------------
    // debouncer state record
    // -----------------------------------------------------------
    typedef struct packed {
        logic [31:0] cnt;
        logic        stableLowN;
    } csrg_deb_type;

    // -----------------------------------------------------------
    // open-drain pin group
    // -----------------------------------------------------------
    typedef struct packed {
        logic out;
        logic oe;
    } csrg_od_type;

endpackage

// file: hw/csrg_debounce.sv
// debouncer for the shared reset pin used as a pushbutton
`timescale 1ns/1ps
`include "csrg_params.svh"
module csrg_debounce #(
    parameter int unsigned DEB_CYC = `CSRG_DEBOUNCE_CYC
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic pinInN,
    output wire logic pressed
);

    csrg_pkg::csrg_deb_type deb_ff;
    csrg_pkg::csrg_deb_type nxt_deb;

    // ---------------------------------------------------------------
    // low must stand for the full debounce time
    // ---------------------------------------------------------------
    always_comb begin
        nxt_deb = deb_ff;
        if (!enable || pinInN) begin
            nxt_deb.cnt        = `CSRG_CNT_ZERO;
            nxt_deb.stableLowN = 1'b1;
        end else if (deb_ff.cnt >= DEB_CYC - 1) begin
            nxt_deb.stableLowN = 1'b0;
        end else begin
            nxt_deb.cnt = deb_ff.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            deb_ff.cnt        <= `CSRG_CNT_ZERO;
            deb_ff.stableLowN <= 1'b1;
        end else begin
            deb_ff <= nxt_deb;
        end
    end

    assign pressed = ~deb_ff.stableLowN;

endmodule

// file: hw/csrg_supervisor.sv
// processor supervisor: reset, watchdog and sram guard
`timescale 1ns/1ps
`include "csrg_params.svh"
module csrg_supervisor #(
    parameter int unsigned HOLD_CYC = `CSRG_RESET_HOLD_CYC,
    parameter int unsigned DOG_CYC  = `CSRG_WATCHDOG_CYC,
    parameter int unsigned DEB_CYC  = `CSRG_DEBOUNCE_CYC
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic supplyOk,
    input  wire logic supplyBelowSwitch,
    input  wire logic watchdog_kick_n,
    input  wire logic ram_select_in_n,
    input  wire logic rstPinIn,
    output wire logic rstPinOut,
    output wire logic rstPinOe,
    output wire logic ram_select_out_n,
    output wire logic sram_supply_out,
    output wire logic powerFail
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    csrg_pkg::csrg_sup_type sup_ff;
    csrg_pkg::csrg_sup_type nxt_sup;
    logic                   buttonPressed;
    logic                   buttonEnable;
    logic                   holdDone;
    logic                   dogExpired;

    // ---------------------------------------------------------------
    // pushbutton on the reset pin
    // ---------------------------------------------------------------
    // button watched only when released
    always_comb begin
        buttonEnable = 1'b0;
        if ((sup_ff.state == csrg_pkg::SUP_RUN) && !sup_ff.rstDriveOe) begin
            buttonEnable = 1'b1;
        end
    end

    csrg_debounce #(
        .DEB_CYC (DEB_CYC)
    ) u_debounce (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .enable  (buttonEnable),
        .pinInN  (rstPinIn),
        .pressed (buttonPressed)
    );

    // ---------------------------------------------------------------
    // counters
    // ---------------------------------------------------------------
    always_comb begin
        holdDone   = 1'b0;
        dogExpired = 1'b0;
        if (sup_ff.holdCnt >= HOLD_CYC - 1) begin
            holdDone = 1'b1;
        end
        if (sup_ff.dogCnt >= DOG_CYC - 1) begin
            dogExpired = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_sup = sup_ff;
        unique case (sup_ff.state)
            // --------------------------------------------------
            // power-up interval
            // --------------------------------------------------
            csrg_pkg::SUP_POWERUP: begin
                nxt_sup.holdCnt = sup_ff.holdCnt + 32'h0000_0001;
                nxt_sup.dogCnt  = `CSRG_CNT_ZERO;
                if (!supplyOk) begin
                    nxt_sup.state = csrg_pkg::SUP_FAIL;
                end else if (holdDone) begin
                    nxt_sup.state   = csrg_pkg::SUP_RUN;
                    nxt_sup.holdCnt = `CSRG_CNT_ZERO;
                end
            end

            // --------------------------------------------------
            // supply out of tolerance
            // --------------------------------------------------
            csrg_pkg::SUP_FAIL: begin
                nxt_sup.holdCnt = `CSRG_CNT_ZERO;
                nxt_sup.dogCnt  = `CSRG_CNT_ZERO;
                if (supplyOk) begin
                    nxt_sup.state = csrg_pkg::SUP_HOLD;
                end
            end

            // --------------------------------------------------
            // reset hold interval
            // --------------------------------------------------
            csrg_pkg::SUP_HOLD: begin
                nxt_sup.holdCnt = sup_ff.holdCnt + 32'h0000_0001;
                nxt_sup.dogCnt  = `CSRG_CNT_ZERO;
                if (!supplyOk) begin
                    nxt_sup.state = csrg_pkg::SUP_FAIL;
                end else if (holdDone) begin
                    nxt_sup.state   = csrg_pkg::SUP_RUN;
                    nxt_sup.holdCnt = `CSRG_CNT_ZERO;
                end
            end

            // --------------------------------------------------
            // processor running
            // --------------------------------------------------
            csrg_pkg::SUP_RUN: begin
                nxt_sup.holdCnt = `CSRG_CNT_ZERO;
                if (!watchdog_kick_n) begin
                    nxt_sup.dogCnt = `CSRG_CNT_ZERO;
                end else begin
                    nxt_sup.dogCnt = sup_ff.dogCnt + 32'h0000_0001;
                end
                if (!supplyOk) begin
                    nxt_sup.state = csrg_pkg::SUP_FAIL;
                end else if (buttonPressed) begin
                    nxt_sup.state = csrg_pkg::SUP_HOLD;
                end else if (dogExpired && watchdog_kick_n) begin
                    nxt_sup.state = csrg_pkg::SUP_HOLD;
                end
            end

            // --------------------------------------------------
            // illegal code: treat as supply fault
            // --------------------------------------------------
            default: begin
                nxt_sup.state   = csrg_pkg::SUP_FAIL;
                nxt_sup.holdCnt = `CSRG_CNT_ZERO;
                nxt_sup.dogCnt  = `CSRG_CNT_ZERO;
            end
        endcase

        // -----------------------------------------------------------
        // reset drive and power-fail flag
        // -----------------------------------------------------------
        // reset drive and power-fail flag
        if (nxt_sup.state == csrg_pkg::SUP_RUN) begin
            nxt_sup.rstDriveOe = 1'b0;
        end else begin
            nxt_sup.rstDriveOe = 1'b1;
        end
        if (!supplyOk) begin
            nxt_sup.powerFail = 1'b1;
        end else begin
            nxt_sup.powerFail = 1'b0;
        end

        // -----------------------------------------------------------
        // gated sram select
        // -----------------------------------------------------------
        // gated sram select
        if (!supplyOk) begin
            nxt_sup.ramSelectOutN = 1'b1;
        end else if (nxt_sup.state == csrg_pkg::SUP_FAIL) begin
            nxt_sup.ramSelectOutN = 1'b1;
        end else if (nxt_sup.state == csrg_pkg::SUP_POWERUP) begin
            nxt_sup.ramSelectOutN = 1'b1;
        end else begin
            nxt_sup.ramSelectOutN = ram_select_in_n;
        end

        // -----------------------------------------------------------
        // sram supply source
        // -----------------------------------------------------------
        // battery switchover
        if (supplyBelowSwitch) begin
            nxt_sup.batterySelect = 1'b1;
        end else begin
            nxt_sup.batterySelect = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sup_ff.state         <= csrg_pkg::SUP_POWERUP;
            sup_ff.holdCnt       <= `CSRG_CNT_ZERO;
            sup_ff.dogCnt        <= `CSRG_CNT_ZERO;
            sup_ff.rstDriveOe    <= 1'b1;
            sup_ff.powerFail     <= 1'b0;
            sup_ff.ramSelectOutN <= 1'b1;
            sup_ff.batterySelect <= 1'b0;
        end else begin
            sup_ff <= nxt_sup;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // open-drain: only ever pulls low
    assign rstPinOut        = 1'b0;
    assign rstPinOe         = sup_ff.rstDriveOe;
    assign ram_select_out_n = sup_ff.ramSelectOutN;
    assign sram_supply_out  = sup_ff.batterySelect;
    assign powerFail        = sup_ff.powerFail;

endmodule

// file: testbench/csrg_host_model.sv
// host side: watchdog strobes and reset wire with pull-up
`timescale 1ns/1ps
module csrg_host_model (
    input  wire logic clk_sys,
    input  wire logic kickEn,
    input  wire logic pressN,
    input  wire logic rstPinOut,
    input  wire logic rstPinOe,
    output logic      watchdog_kick_n,
    output wire logic rstWire
);
    logic [3:0] tick = 4'h0;
    assign rstWire = (rstPinOe && !rstPinOut) ? 1'b0 : pressN;
    always @(posedge clk_sys) begin
        tick <= tick + 4'h1;
        watchdog_kick_n <= !(kickEn && tick == 4'h0);
    end
endmodule

// file: testbench/csrg_supervisor_assertions.sv
// assertions on the supervisor ports
`timescale 1ns/1ps
module csrg_supervisor_assertions #(
    parameter int unsigned HOLD_CYC = 20,
    parameter int unsigned DOG_CYC  = 50,
    parameter int unsigned DEB_CYC  = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic supplyOk,
    input wire logic supplyBelowSwitch,
    input wire logic watchdog_kick_n,
    input wire logic ram_select_in_n,
    input wire logic rstPinIn,
    input wire logic rstPinOut,
    input wire logic rstPinOe,
    input wire logic ram_select_out_n,
    input wire logic sram_supply_out,
    input wire logic powerFail
);
    localparam int HOLD_M = HOLD_CYC - 1;
    logic [31:0] kickAge;
    logic [31:0] lowRun;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // cycles since last strobe, and since button went low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            kickAge <= 32'h0;
            lowRun  <= 32'h0;
        end else begin
            kickAge <= (!watchdog_kick_n || rstPinOe) ? 32'h0 : kickAge + 32'h1;
            lowRun  <= (!rstPinIn && !rstPinOe) ? lowRun + 32'h1 : 32'h0;
        end
    end
    fail_blocks_all_a: assert property (
        !supplyOk |=> rstPinOe && powerFail && ram_select_out_n)
        else $error("supply fault not handled");
    hold_after_fail_a: assert property (
        $fell(powerFail) |-> ##HOLD_M rstPinOe ##1 !rstPinOe)
        else $error("wrong hold after supply recovery");
    button_reset_a: assert property (
        lowRun == DEB_CYC + 1 |-> ##[0:3] rstPinOe)
        else $error("button press gave no reset");
    reset_long_a: assert property (
        $rose(rstPinOe) && supplyOk |-> ##HOLD_M rstPinOe)
        else $error("reset pulse too short");
    dog_expiry_a: assert property (
        kickAge == DOG_CYC - 3 |-> ##[0:6] rstPinOe)
        else $error("watchdog expiry gave no reset");
    kick_keeps_run_a: assert property (
        $rose(rstPinOe) && supplyOk && lowRun == 32'h0
        |-> kickAge >= DOG_CYC - 3)
        else $error("reset despite timely strobes");
    select_pass_a: assert property (
        supplyOk && !rstPinOe |=> ram_select_out_n == $past(ram_select_in_n))
        else $error("select not passed through");
    battery_follow_a: assert property (
        supplyBelowSwitch != sram_supply_out
        |=> sram_supply_out == $past(supplyBelowSwitch))
        else $error("sram supply not switched");
    open_drain_a: assert property (
        rstPinOe |-> !rstPinOut)
        else $error("reset pin driven high");
endmodule

// file: testbench/csrg_supervisor_tb.sv
// self-checking bench for the supervisor
`timescale 1ns/1ps
module csrg_supervisor_tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, supplyOk = 1'b1, kickEn = 1'b0;
    logic supplyBelowSwitch = 1'b0, ram_select_in_n = 1'b1, pressN = 1'b1;
    logic watchdog_kick_n, rstWire, rstPinOut, rstPinOe;
    logic ram_select_out_n, sram_supply_out, powerFail;
    int   miscompares = 0, total_checks = 0, cycles = 0, n;
    csrg_supervisor #(.HOLD_CYC(20), .DOG_CYC(50), .DEB_CYC(4)) i_dut (
        .clk_sys, .reset_n, .supplyOk, .supplyBelowSwitch,
        .watchdog_kick_n, .ram_select_in_n, .rstPinIn(rstWire),
        .rstPinOut, .rstPinOe, .ram_select_out_n, .sram_supply_out,
        .powerFail);
    csrg_host_model i_host (.clk_sys, .kickEn, .pressN, .rstPinOut,
        .rstPinOe, .watchdog_kick_n, .rstWire);
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test;
        end
    end
    task check(logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task waitOe(logic val);
        n = 0;
        while (rstPinOe !== val && n < 500) begin
            @(posedge clk_sys); #1;
            n++;
        end
        check(rstPinOe, val);
    endtask
    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task t_powerup;
        @(posedge clk_sys) ram_select_in_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 check(ram_select_out_n, 1'b1);
        waitOe(1'b0);
        $display("test powerup done");
    endtask
    task t_select;
        @(posedge clk_sys) ram_select_in_n <= 1'b1;
        @(posedge clk_sys) ram_select_in_n <= 1'b0;
        #1 check(ram_select_out_n, 1'b1);
        @(posedge clk_sys); #1 check(ram_select_out_n, 1'b0);
        $display("test select done");
    endtask
    task t_supply;
        @(posedge clk_sys) supplyOk <= 1'b0;
        supplyBelowSwitch <= 1'b1;
        @(posedge clk_sys); #1 check(powerFail, 1'b1);
        check(rstPinOe, 1'b1);
        check(ram_select_out_n, 1'b1);
        check(sram_supply_out, 1'b1);
        @(posedge clk_sys) supplyOk <= 1'b1;
        supplyBelowSwitch <= 1'b0;
        n = 0;
        while (powerFail !== 1'b0 && n < 10) begin
            @(posedge clk_sys); #1;
            n++;
        end
        check(sram_supply_out, 1'b0);
        n = 0;
        while (rstPinOe === 1'b1 && n < 100) begin
            @(posedge clk_sys); #1;
            n++;
        end
        check(n, 20);
        $display("test supply done");
    endtask
    task t_watchdog;
        n = 0;
        repeat (200) begin
            @(posedge clk_sys); #1;
            if (rstPinOe !== 1'b0) n++;
        end
        check(n, 0);
        @(posedge clk_sys) kickEn <= 1'b0;
        waitOe(1'b1);
        @(posedge clk_sys) kickEn <= 1'b1;
        waitOe(1'b0);
        $display("test watchdog done");
    endtask
    task t_button;
        @(posedge clk_sys) pressN <= 1'b0;
        waitOe(1'b1);
        @(posedge clk_sys) pressN <= 1'b1;
        n = 1;
        while (rstPinOe === 1'b1 && n < 100) begin
            @(posedge clk_sys); #1;
            n++;
        end
        check(n >= 20, 1'b1);
        $display("test button done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        kickEn <= 1'b1;
        t_powerup;
        t_select;
        t_supply;
        t_watchdog;
        t_button;
        end_of_test;
    end
endmodule
bind csrg_supervisor csrg_supervisor_assertions #(.HOLD_CYC(HOLD_CYC),
    .DOG_CYC(DOG_CYC), .DEB_CYC(DEB_CYC)) i_chk (.clk_sys, .reset_n,
    .supplyOk, .supplyBelowSwitch, .watchdog_kick_n, .ram_select_in_n,
    .rstPinIn, .rstPinOut, .rstPinOe, .ram_select_out_n,
    .sram_supply_out, .powerFail);
